/* File: design/osct_pkg.sv */
package osct_pkg;
   localparam int          OSCT_NUM_TIMERS = 2;
   localparam int          OSCT_CW         = 32;
   localparam logic [31:0] OSCT_COUNT_RST  = 32'h0000_0000;
   localparam logic [31:0] OSCT_RELOAD_RST = 32'h0000_0000;
   localparam logic [31:0] OSCT_ZERO       = 32'h0000_0000;
   localparam logic [31:0] OSCT_ONE        = 32'h0000_0001;
   localparam logic        OSCT_EN_RST     = 1'b0;
   localparam logic        OSCT_FLAG_RST   = 1'b0;
   localparam logic        OSCT_MODE_RST   = 1'b0;
   localparam logic        OSCT_PROT_RST   = 1'b0;

   typedef enum logic [1:0]
   {
      OSCT_SEL_COUNT  = 2'h0,
      OSCT_SEL_RELOAD = 2'h1,
      OSCT_SEL_MODE   = 2'h2,
      OSCT_SEL_FLAG   = 2'h3
   } osct_sel_t;
endpackage

/* File: design/osct_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface osct_if;
   import osct_pkg::*;
   logic              wr;
   logic              rd;
   logic              user;
   logic [1:0]        sel;
   logic [31:0]       wdata;
   logic [31:0]       rdata;
   logic              fault;
   logic              expire;
   logic              run;
   logic [31:0]       count;

   modport ctl (output wr, output rd, output user, output sel, output wdata,
                input rdata, input fault, input expire, input run, input count);
   modport tmr (input wr, input rd, input user, input sel, input wdata,
                output rdata, output fault, output expire, output run, output count);
endinterface
`default_nettype wire

/* File: design/osct_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module osct_timer
   import osct_pkg::*;
(
   input  wire logic CLOCK,
   input  wire logic RSTN,
   osct_if.tmr       bus
);
   logic [31:0] count_r;
   logic [31:0] reload_r;
   logic        en_r;
   logic        periodic_r;
   logic        prot_r;
   logic        flag_r;
   logic [31:0] rdata_r;
   logic        fault_r;
   logic        wr_ok;
   logic        at_one;
   logic        expire;

   ////////////////////////////////////////////////////////////////////
   assign wr_ok  = bus.wr && !(prot_r && bus.user);
   assign at_one = en_r && (count_r == OSCT_ONE);
   assign expire = at_one;

   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
         count_r <= OSCT_COUNT_RST;
      else if (wr_ok && bus.sel == OSCT_SEL_COUNT)
         count_r <= bus.wdata;
      else if (expire && periodic_r)
         count_r <= reload_r;
      else if (en_r && count_r != OSCT_ZERO)
         count_r <= count_r - OSCT_ONE;
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
         reload_r <= OSCT_RELOAD_RST;
      else if (wr_ok && bus.sel == OSCT_SEL_RELOAD)
         reload_r <= bus.wdata;
   end

   // mode word: bit0 run, bit1 periodic, bit2 user-write protect
   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
      begin
         en_r       <= OSCT_EN_RST;
         periodic_r <= OSCT_MODE_RST;
         prot_r     <= OSCT_PROT_RST;
      end
      else if (wr_ok && bus.sel == OSCT_SEL_MODE)
      begin
         en_r       <= bus.wdata[0];
         periodic_r <= bus.wdata[1];
         prot_r     <= bus.wdata[2];
      end
      else if (expire && !periodic_r)
         en_r <= 1'b0;
      else if (en_r && count_r == OSCT_ZERO && !periodic_r)
         en_r <= 1'b0;
   end

   // read never clears; only an explicit write of 1 clears, and set wins
   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
         flag_r <= OSCT_FLAG_RST;
      else if (expire)
         flag_r <= 1'b1;
      else if (wr_ok && bus.sel == OSCT_SEL_FLAG && bus.wdata[0])
         flag_r <= 1'b0;
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
      begin
         rdata_r <= OSCT_ZERO;
         fault_r <= 1'b0;
      end
      else
      begin
         fault_r <= bus.wr && !wr_ok;
         if (bus.rd)
         begin
            case (bus.sel)
               OSCT_SEL_COUNT:  rdata_r <= count_r;
               OSCT_SEL_RELOAD: rdata_r <= reload_r;
               OSCT_SEL_MODE:   rdata_r <= {29'h0000_0000, prot_r, periodic_r, en_r};
               OSCT_SEL_FLAG:   rdata_r <= {31'h0000_0000, flag_r};
               default:         rdata_r <= OSCT_ZERO;
            endcase
         end
      end
   end

   assign bus.rdata  = rdata_r;
   assign bus.fault  = fault_r;
   assign bus.expire = expire;
   assign bus.run    = en_r;
   assign bus.count  = count_r;
endmodule
`default_nettype wire

/* File: design/osct_top.sv */
`timescale 1ns/100ps
`default_nettype none
module osct_top
   import osct_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RSTN,
   input  wire logic        WR,
   input  wire logic        RD,
   input  wire logic        USER_MODE,
   input  wire logic        TSEL,
   input  wire logic [1:0]  SEL,
   input  wire logic [31:0] WDATA,
   output logic      [31:0] RDATA,
   output logic             TYPE_MISMATCH_FAULT,
   output logic      [1:0]  TIMER_IRQ,
   output logic      [1:0]  TIMER_RUN
);
   logic [31:0] rd_v [OSCT_NUM_TIMERS];
   logic [1:0]  flt_v;
   logic [1:0]  irq_r;
   logic [1:0]  exp_v;
   logic        tsel_r;

   ////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < OSCT_NUM_TIMERS; g++)
      begin : gt
         osct_if b ();
         assign b.wr    = WR && (TSEL == 1'(g));
         assign b.rd    = RD && (TSEL == 1'(g));
         assign b.user  = USER_MODE;
         assign b.sel   = SEL;
         assign b.wdata = WDATA;
         osct_timer u_t (.CLOCK(CLOCK), .RSTN(RSTN), .bus(b));
         assign rd_v[g]      = b.rdata;
         assign flt_v[g]     = b.fault;
         assign TIMER_RUN[g] = b.run;
         assign exp_v[g]     = b.expire;
      end
   endgenerate

   // one process for the whole vector: per-bit processes would split one driver
   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
         irq_r <= 2'h0;
      else
         irq_r <= exp_v;
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RSTN)
         tsel_r <= 1'b0;
      else if (RD)
         tsel_r <= TSEL;
   end

   assign RDATA               = rd_v[tsel_r];
   assign TYPE_MISMATCH_FAULT = |flt_v;
   assign TIMER_IRQ           = irq_r;
endmodule
`default_nettype wire

/* File: sim/osct_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module osct_checker
(
   input wire logic        CLOCK,
   input wire logic        RSTN,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic        USER_MODE,
   input wire logic        TSEL,
   input wire logic [1:0]  SEL,
   input wire logic [31:0] RDATA,
   input wire logic        TYPE_MISMATCH_FAULT,
   input wire logic [1:0]  TIMER_IRQ,
   input wire logic [1:0]  TIMER_RUN
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   fault_cause_a: assert property (TYPE_MISMATCH_FAULT |-> $past(WR && USER_MODE))
      else $error("stray fault");
   sup_write_a: assert property (WR && !USER_MODE |=> !TYPE_MISMATCH_FAULT)
      else $error("supervisor fault");
   fault_pulse_a: assert property (TYPE_MISMATCH_FAULT && !WR |=> !TYPE_MISMATCH_FAULT)
      else $error("long fault");
   irq0_cause_a: assert property (TIMER_IRQ[0] |-> $past(TIMER_RUN[0]) || $past(TIMER_RUN[0], 2))
      else $error("idle irq0");
   irq1_cause_a: assert property (TIMER_IRQ[1] |-> $past(TIMER_RUN[1]) || $past(TIMER_RUN[1], 2))
      else $error("idle irq1");
   run0_start_a: assert property ($rose(TIMER_RUN[0]) |-> $past(WR && !TSEL && SEL == 2'h2))
      else $error("run0 self start");
   run1_start_a: assert property ($rose(TIMER_RUN[1]) |-> $past(WR && TSEL && SEL == 2'h2))
      else $error("run1 self start");
   rdata_hold_a: assert property (!$past(RD) |-> $stable(RDATA))
      else $error("rdata moved");
   cover property (TYPE_MISMATCH_FAULT);
   cover property (TIMER_IRQ[0]);
   cover property (TIMER_IRQ[1]);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, user = 1'b0, tsel = 1'b0;
   logic        fault, ck = 1'b0, ck_d = 1'b0;
   logic [1:0]  sel = 2'h0, irq, run;
   logic [31:0] wdata = 32'h0, rdata, n, q[$], iq[$];
   int          seed = 32'h592362E4, bad_count = 0, n_tests = 0;
   osct_top dut (.CLOCK(clock), .RSTN(rstn), .WR(wr), .RD(rd), .USER_MODE(user), .TSEL(tsel),
      .SEL(sel), .WDATA(wdata), .RDATA(rdata), .TYPE_MISMATCH_FAULT(fault), .TIMER_IRQ(irq),
      .TIMER_RUN(run));
   always #20 clock = ~clock;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // write when w, else read expecting d; one idle edge between accesses
   task automatic acc(input logic w, input logic t, input logic [1:0] s, input logic [31:0] d);
      @(posedge clock);
      #1;
      {wr, rd, ck, tsel, sel, wdata} = {w, !w, !w, t, s, d};
      if (!w)
         q.push_back(d);
      @(posedge clock);
      #1;
      {wr, rd, ck} = 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clock)
   begin
      if (ck_d)
         chk("rdata", rdata, q.pop_front());
      if (rstn && irq !== 2'h0)
         chk("irq", 32'(irq), iq.pop_front());
      ck_d <= ck;
   end
   initial
   begin
      #100000;
      bad_count++;
      final_report();
   end
   initial
   begin
      repeat (12) @(posedge clock);
      #1;
      rstn = 1'b1;
      chk("run", 32'(run), 32'h0);
      for (int t = 0; t < 2; t++)
      begin
         n = 32'h3 + ($random(seed) & 32'h7);
         acc(1'b1, t[0], 2'h0, n);
         acc(1'b1, t[0], 2'h2, 32'h1);
         iq.push_back(32'h1 << t);
         @(posedge clock);
         #1;
         // poll flag every cycle so a read lands on the setting edge
         {rd, sel} = 3'h7;
         repeat (n + 2) @(posedge clock);
         #1;
         rd = 1'b0;
         chk("run", 32'(run), 32'h0);
         acc(1'b0, t[0], 2'h3, 32'h1);
         acc(1'b0, t[0], 2'h0, 32'h0);
      end
      acc(1'b1, 1'b0, 2'h1, 32'h4);
      acc(1'b1, 1'b0, 2'h0, 32'h4);
      // period of four: expiries on edges 4, 8, 12, 16, 20 after the start
      repeat (5) iq.push_back(32'h1);
      acc(1'b1, 1'b0, 2'h2, 32'h3);
      repeat (20) @(posedge clock);
      #1;
      chk("run", 32'(run), 32'h1);
      // stop before the sixth expiry so the irq count is exact
      acc(1'b1, 1'b0, 2'h2, 32'h0);
      acc(1'b1, 1'b1, 2'h2, 32'h4);
      user = 1'b1;
      acc(1'b1, 1'b1, 2'h0, 32'h9);
      chk("fault", 32'(fault), 32'h1);
      user = 1'b0;
      acc(1'b0, 1'b1, 2'h0, 32'h0);
      repeat (3) @(posedge clock);
      chk("irq_left", 32'(iq.size()), 32'h0);
      final_report();
   end
endmodule
bind osct_top osct_checker chk_i (.*);
`default_nettype wire
